// ### hw/sdid_regs.sv
// drive level and identification registers for channels 2 and 3
// assumes the serial front end gives one-cycle read/write strobes on clk
//
// Function
// - each of channels 2 and 3 holds a five-bit drive setting in bits 15:11, used while it converts.
// - the programmed setting drives the sensor only while the override enable is 1.
// - bits 10:6 of each drive register read the calibrated initial drive level.
// - the calibrated field reloads after each amplitude correction only while correction is enabled.
// - address 0x7E reads a fixed sixteen-bit maker code.
// - address 0x7F reads a fixed part code.
`timescale 1ns/1ps
module sdid_regs #(
   parameter logic [15:0] MAKER_CODE = 16'hA5C3,  // arbitrary value
   parameter logic [15:0] PART_CODE  = 16'h1D02   // arbitrary value
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst,
   // register access
   input  wire logic [7:0]  reg_addr,
   input  wire logic        reg_wr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_rd,
   output logic      [15:0] reg_rdata,
   output logic             reg_rvalid,
   // conversion core
   input  wire logic        drive_override_enable,
   input  wire logic        amplitude_correction_disable,
   input  wire logic [1:0]  active_channel,
   input  wire logic        amp_corr_done,
   input  wire logic [4:0]  amp_corr_level,
   input  wire logic [4:0]  auto_drive_level,
   output logic      [4:0]  ch2_drive_setting,
   output logic      [4:0]  ch3_drive_setting,
   output logic      [4:0]  ch2_calibrated_drive,
   output logic      [4:0]  ch3_calibrated_drive,
   output logic      [4:0]  sensor_drive
);
   // ------------------------------------------------------------
   // elaboration checks
   // ------------------------------------------------------------
   // the read word is a plain concatenation, so the package positions must
   // tile it as setting, calibrated field and reserved bits from the top down
   if (sdid_pkg::SETTING_MSB != 15 || sdid_pkg::SETTING_MSB - sdid_pkg::SETTING_LSB != 4)
   begin : g_bad_setting
      $error("drive setting field must be five bits ending at bit 15");
   end
   if (sdid_pkg::CALIB_MSB != sdid_pkg::SETTING_LSB - 1 ||
       sdid_pkg::CALIB_MSB - sdid_pkg::CALIB_LSB != 4 || sdid_pkg::CALIB_LSB != 6)
   begin : g_bad_calib
      $error("calibrated field must be five bits right below the setting");
   end

   // ------------------------------------------------------------
   // decode
   // ------------------------------------------------------------
   wire logic [4:0]  wr_setting = reg_wdata[sdid_pkg::SETTING_MSB:sdid_pkg::SETTING_LSB];
   wire logic        upd_ok     = amp_corr_done && !amplitude_correction_disable;
   logic      [4:0]  setting_reg  [2];
   logic      [4:0]  setting_next [2];
   logic      [4:0]  calib_reg    [2];
   logic      [4:0]  calib_next   [2];
   logic      [15:0] drive_word   [2];
   logic      [15:0] rd_mux;
   logic      [15:0] rdata_reg;
   logic      [15:0] rdata_next;
   logic             rvalid_reg;

   // ------------------------------------------------------------
   // channel registers: slot 0 is channel 2, slot 1 is channel 3
   // ------------------------------------------------------------
   for (genvar i = 0; i < 2; i++)
   begin : g_chan
      localparam logic [1:0] CHAN = 2'(i + 2);
      localparam logic [7:0] ADDR = (i == 0) ? sdid_pkg::CHAN2_DRIVE_LEVEL_ADDR
                                             : sdid_pkg::CHAN3_DRIVE_LEVEL_ADDR;
      wire logic             wr_hit  = reg_wr && reg_addr == ADDR;
      wire logic             upd_hit = upd_ok && active_channel == CHAN;

      // only the setting bits of a host write are kept; the calibrated and
      // reserved positions of the word are dropped here
      assign setting_next[i] = wr_hit ? wr_setting : setting_reg[i];
      // no host path reaches the calibrated field, only the correction result
      assign calib_next[i]   = upd_hit ? amp_corr_level : calib_reg[i];
      assign drive_word[i]   = {setting_reg[i], calib_reg[i], 6'h00};

      always_ff @(posedge clk)
      begin
         if (rst)
         begin
            setting_reg[i] <= sdid_pkg::SETTING_RESET;
            calib_reg[i]   <= sdid_pkg::CALIB_RESET;
         end
         else
         begin
            setting_reg[i] <= setting_next[i];
            calib_reg[i]   <= calib_next[i];
         end
      end
   end

   assign ch2_drive_setting    = setting_reg[0];
   assign ch3_drive_setting    = setting_reg[1];
   assign ch2_calibrated_drive = calib_reg[0];
   assign ch3_calibrated_drive = calib_reg[1];

   // ------------------------------------------------------------
   // channel checks
   // ------------------------------------------------------------
   a_setting2_write: assert property (@(posedge clk) disable iff (rst)
      reg_wr && reg_addr == 8'h20 |=> ch2_drive_setting == $past(reg_wdata[15:11]))
      else $error("channel 2 setting not stored");

   a_setting3_write: assert property (@(posedge clk) disable iff (rst)
      reg_wr && reg_addr == 8'h21 |=> ch3_drive_setting == $past(reg_wdata[15:11]))
      else $error("channel 3 setting not stored");

   a_setting_hold: assert property (@(posedge clk) disable iff (rst)
      !reg_wr |=> $stable(ch2_drive_setting) && $stable(ch3_drive_setting))
      else $error("drive setting changed without a write");

   a_calib_hold: assert property (@(posedge clk) disable iff (rst)
      amplitude_correction_disable
      |=> $stable(ch2_calibrated_drive) && $stable(ch3_calibrated_drive))
      else $error("calibrated field changed while correction disabled");

   a_calib2_update: assert property (@(posedge clk) disable iff (rst)
      amp_corr_done && !amplitude_correction_disable && active_channel == 2'h2
      |=> ch2_calibrated_drive == $past(amp_corr_level))
      else $error("channel 2 calibrated field not refreshed");

   a_calib3_update: assert property (@(posedge clk) disable iff (rst)
      amp_corr_done && !amplitude_correction_disable && active_channel == 2'h3
      |=> ch3_calibrated_drive == $past(amp_corr_level))
      else $error("channel 3 calibrated field not refreshed");

   a_calib_nowrite: assert property (@(posedge clk) disable iff (rst)
      !amp_corr_done |=> $stable(ch2_calibrated_drive) && $stable(ch3_calibrated_drive))
      else $error("calibrated field moved without a correction result");

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   always_comb
   begin
      case (reg_addr)
         sdid_pkg::CHAN2_DRIVE_LEVEL_ADDR: rd_mux = drive_word[0];
         sdid_pkg::CHAN3_DRIVE_LEVEL_ADDR: rd_mux = drive_word[1];
         sdid_pkg::MAKER_IDENT_ADDR:       rd_mux = MAKER_CODE;
         sdid_pkg::PART_IDENT_ADDR:        rd_mux = PART_CODE;
         // unmapped addresses read zero so a wrong address is easy to spot
         default:                          rd_mux = 16'h0000;
      endcase
   end

   // read data stays until the next read, so a slow host may pick it up late
   assign rdata_next = reg_rd ? rd_mux : rdata_reg;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rdata_reg  <= sdid_pkg::RDATA_RESET;
         rvalid_reg <= 1'h0;
      end
      else
      begin
         rdata_reg  <= rdata_next;
         rvalid_reg <= reg_rd;
      end
   end

   assign reg_rdata  = rdata_reg;
   assign reg_rvalid = rvalid_reg;

   // ------------------------------------------------------------
   // read checks
   // ------------------------------------------------------------
   a_setting_read: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == 8'h20 |=> reg_rdata[15:11] == $past(ch2_drive_setting))
      else $error("drive setting misread");

   a_calib_read: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == 8'h21
      |=> reg_rvalid && reg_rdata[10:6] == $past(ch3_calibrated_drive))
      else $error("calibrated field misread");

   a_maker_read: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == 8'h7E |=> reg_rdata == MAKER_CODE)
      else $error("maker code misread");

   a_part_read: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr == 8'h7F |=> reg_rdata == PART_CODE)
      else $error("part code misread");

   a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
      reg_rd && (reg_addr == 8'h20 || reg_addr == 8'h21) |=> reg_rdata[5:0] == 6'h00)
      else $error("reserved bits not zero");

   a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
      reg_rd && reg_addr[7:1] != 7'h10 && reg_addr[7:1] != 7'h3F |=> reg_rdata == 16'h0000)
      else $error("unmapped address did not read zero");

   a_rvalid_rise: assert property (@(posedge clk) disable iff (rst)
      reg_rd |=> reg_rvalid)
      else $error("read not answered");

   a_rvalid_drop: assert property (@(posedge clk) disable iff (rst)
      !reg_rd |=> !reg_rvalid && $stable(reg_rdata))
      else $error("read answer without a read");

   // ------------------------------------------------------------
   // sensor drive
   // ------------------------------------------------------------
   // channels 0/1 are outside this slice; the core's own level is used there
   always_comb
   begin
      if (drive_override_enable && active_channel == 2'h2)
         sensor_drive = ch2_drive_setting;
      else if (drive_override_enable && active_channel == 2'h3)
         sensor_drive = ch3_drive_setting;
      else
         sensor_drive = auto_drive_level;
   end

   // ------------------------------------------------------------
   // drive checks
   // ------------------------------------------------------------
   a_override_gate: assert property (@(posedge clk) disable iff (rst)
      !drive_override_enable |-> sensor_drive == auto_drive_level)
      else $error("drive override used while disabled");

   a_override_ch2: assert property (@(posedge clk) disable iff (rst)
      drive_override_enable && active_channel == 2'h2 |-> sensor_drive == ch2_drive_setting)
      else $error("channel 2 setting not applied");

   a_override_ch3: assert property (@(posedge clk) disable iff (rst)
      drive_override_enable && active_channel == 2'h3 |-> sensor_drive == ch3_drive_setting)
      else $error("channel 3 setting not applied");

   a_other_chan: assert property (@(posedge clk) disable iff (rst)
      !active_channel[1] |-> sensor_drive == auto_drive_level)
      else $error("setting applied outside channels 2 and 3");
endmodule : sdid_regs

// ### hw/sdid_pkg.sv
// register map constants for the channel 2/3 drive and identification slice
// assumes a serial register front end that hands over 8-bit addresses and 16-bit words
package sdid_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0]  CHAN2_DRIVE_LEVEL_ADDR = 8'h20;
   localparam logic [7:0]  CHAN3_DRIVE_LEVEL_ADDR = 8'h21;
   localparam logic [7:0]  MAKER_IDENT_ADDR       = 8'h7E;
   localparam logic [7:0]  PART_IDENT_ADDR        = 8'h7F;
   // ------------------------------------------------------------
   // drive register fields
   // ------------------------------------------------------------
   localparam int          SETTING_LSB            = 11;
   localparam int          SETTING_MSB            = 15;
   localparam int          CALIB_LSB              = 6;
   localparam int          CALIB_MSB              = 10;
   localparam logic [4:0]  SETTING_RESET          = 5'h00;
   localparam logic [4:0]  CALIB_RESET            = 5'h00;
   localparam logic [15:0] RDATA_RESET            = 16'h0000;
endpackage : sdid_pkg

// ### verification/sdid_host.sv
// host model: register reads and writes with one-cycle strobes
// tasks are entered just after a rising clk edge
`timescale 1ns/1ps
module sdid_host (
   // register access
   input  wire logic        clk,
   output logic      [7:0]  reg_addr,
   output logic             reg_wr,
   output logic      [15:0] reg_wdata,
   output logic             reg_rd,
   input  wire logic [15:0] reg_rdata
);
   initial {reg_addr, reg_wr, reg_wdata, reg_rd} = '0;
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr  = a;
      reg_wdata = d & 16'hF83F;
      reg_wr    = 1'b1;
      @(posedge clk) #1 reg_wr = 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] q);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(posedge clk) #1 reg_rd = 1'b0;
      q = reg_rdata;
   endtask : rd
endmodule : sdid_host

// ### verification/sensor_drive_and_id_regs_tb.sv
// self-checking bench for the drive and identification registers
// assumes the host model drives the register strobes
`timescale 1ns/1ps
module sensor_drive_and_id_regs_tb;
   logic        clk, rst, wr, rd, rv, ovr, dis, done;
   logic [1:0]  chan;
   logic [4:0]  lvl, autol, d2, d3, c2, c3, sd;
   logic [7:0]  addr;
   logic [15:0] wd, rdat, q;
   logic [39:0] rows [5];
   int          n_mismatch, compares;
   sdid_regs #(.MAKER_CODE(16'h6B1E), .PART_CODE(16'h0C47)) u_sdid_regs (
      .clk(clk), .rst(rst), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd),
      .reg_rd(rd), .reg_rdata(rdat), .reg_rvalid(rv), .drive_override_enable(ovr),
      .amplitude_correction_disable(dis), .active_channel(chan), .amp_corr_done(done),
      .amp_corr_level(lvl), .auto_drive_level(autol), .ch2_drive_setting(d2),
      .ch3_drive_setting(d3), .ch2_calibrated_drive(c2), .ch3_calibrated_drive(c3),
      .sensor_drive(sd));
   sdid_host u_sdid_host (.clk(clk), .reg_addr(addr), .reg_wr(wr), .reg_wdata(wd),
      .reg_rd(rd), .reg_rdata(rdat));
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("Error %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   task automatic pulse();
      done = 1'b1;
      @(posedge clk) #1 done = 1'b0;
      @(posedge clk) #1;
   endtask : pulse
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   initial
   begin
      #20000 n_mismatch++;
      test_done();
   end
   initial
   begin
      {rst, ovr, dis, done} = 4'h8;
      {chan, lvl, autol} = {2'h2, 5'h00, 5'h07};
      rows = '{{8'h20, 16'hFFFF, 16'hF800}, {8'h21, 16'hA83F, 16'hA800},
               {8'h7E, 16'h1234, 16'h6B1E}, {8'h7F, 16'hFFFF, 16'h0C47},
               {8'h30, 16'hFFFF, 16'h0000}};
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      foreach (rows[i])
      begin
         u_sdid_host.wr(rows[i][39:32], rows[i][31:16]);
         u_sdid_host.rd(rows[i][39:32], q);
         chk(q, rows[i][15:0]);
         chk({15'h0, rv}, 16'h0001);
      end
      $display("register rows done");
      for (int c = 2; c < 4; c++)
      begin
         {chan, dis, lvl} = {c[1:0], 1'b0, 5'h15};
         pulse();
         {dis, lvl} = {1'b1, 5'h0A};
         pulse();
         u_sdid_host.rd(8'h1E + c[7:0], q);
         chk(q, {(c == 2) ? 5'h1F : 5'h15, 5'h15, 6'h00});
      end
      chk({11'h0, c2}, 16'h0015);
      chk({11'h0, c3}, 16'h0015);
      chk({11'h0, d3}, 16'h0015);
      $display("calibration done");
      chan = 2'h2;
      #1 chk({11'h0, sd}, {11'h0, autol});
      ovr = 1'b1;
      #1 chk({11'h0, sd}, 16'h001F);
      chan = 2'h3;
      #1 chk({11'h0, sd}, 16'h0015);
      $display("override done");
      @(posedge clk) #1 rst = 1'b1;
      @(posedge clk) #1 rst = 1'b0;
      u_sdid_host.rd(8'h20, q);
      chk(q, 16'h0000);
      chk({11'h0, d2}, 16'h0000);
      chk({11'h0, d3}, 16'h0000);
      chk({11'h0, c3}, 16'h0000);
      $display("reset done");
      test_done();
   end
endmodule : sensor_drive_and_id_regs_tb
